/* include/uecor_map.svh */
`ifndef UECOR_MAP_SVH
`define UECOR_MAP_SVH

// Register addresses on the software port
`define UECOR_EP1_LENGTH 16'hFE98
`define UECOR_EP1_RX 16'hFE99
`define UECOR_EP2_LENGTH 16'hFE9A
`define UECOR_EP2_RX 16'hFE9B
`define UECOR_EP3_LENGTH 16'hFE9C
`define UECOR_EP3_RX 16'hFE9D
`define UECOR_EP4_LENGTH 16'hFE9E
`define UECOR_EP4_RX 16'hFE9F
`define UECOR_TEST_CONTROL 16'hFEAC
`define UECOR_TEST_READBACK 16'hFEAD
`define UECOR_BUF_OFFSETS 16'hFEAE

// Reset values
`define UECOR_TEST_CONTROL_RESET 8'h00
`define UECOR_TEST_READBACK_RESET 8'h00
`define UECOR_BUF_OFFSETS_RESET 8'h00
`define UECOR_LEN_RESET 7'h00
`define UECOR_UNMAPPED_READ 8'h00

// Offset field: endpoint n at bits 2n-1:2n-2
`define UECOR_OFS_WIDTH 2

// Buffer windows
`define UECOR_EP1_BUF_BASE 16'h0280
`define UECOR_EP2_BUF_BASE 16'h0300
`define UECOR_EP34_BUF_BASE 16'h0380
`define UECOR_BANK_STEP 16'h0040
`define UECOR_OFS_STEP 16'h0010

// Largest legal length, and the saturation point of the byte counter
`define UECOR_MAX_PAYLOAD 7'h40
`define UECOR_CNT_SAT 7'h7F

// Host gives up on a silent device after this many cycles
`define UECOR_HOST_TIMEOUT 8'hFF

`endif

/* include/uecor_pkg.sv */
`include "uecor_map.svh"

package uecor_pkg;
	typedef logic [7:0] uecor_byte_t;
	typedef logic [6:0] uecor_len_t;
	typedef logic [15:0] uecor_addr_t;
	typedef logic [2:0] uecor_ep_t;

	typedef enum logic [2:0] {DEV_IDLE, DEV_SEND, DEV_WAIT, DEV_RECV} uecor_dev_state_t;
	typedef enum logic [2:0] {HOST_IDLE, HOST_SEND, HOST_WAIT_HS, HOST_RECV} uecor_host_state_t;

	typedef struct packed {
		uecor_dev_state_t st;
		logic [1:0] ep;
		uecor_len_t idx;
		uecor_len_t lim;
		uecor_addr_t ram_addr;
		logic ram_we;
		uecor_byte_t ram_wdata;
		logic dd_valid;
		uecor_byte_t dd_byte;
		logic dd_eop;
		logic d_ack;
		logic d_nak;
		uecor_len_t [3:0] length;
		uecor_len_t [3:0] rx;
		uecor_byte_t test_control;
		uecor_byte_t offsets;
		uecor_byte_t rdata;
	} uecor_dev_t;

	typedef struct packed {
		uecor_host_state_t st;
		logic is_in;
		uecor_len_t len;
		uecor_len_t cnt;
		uecor_byte_t seed;
		uecor_byte_t sum;
		uecor_byte_t timer;
		logic tok_valid;
		logic tok_in;
		uecor_ep_t tok_ep;
		logic hd_valid;
		uecor_byte_t hd_byte;
		logic hd_eop;
		logic h_ack;
		logic ready;
		logic done;
		logic done_ok;
		uecor_len_t done_count;
		uecor_byte_t done_sum;
	} uecor_host_t;
endpackage

/* include/uecor_link_if.sv */
`timescale 1ns/1ps

interface uecor_link_if;
	import uecor_pkg::*;
	logic tok_valid;
	logic tok_in;
	uecor_ep_t tok_ep;
	logic hd_valid;
	uecor_byte_t hd_byte;
	logic hd_eop;
	logic h_ack;
	logic dd_valid;
	uecor_byte_t dd_byte;
	logic dd_eop;
	logic d_ack;
	logic d_nak;

	modport dev (
		input tok_valid, tok_in, tok_ep, hd_valid, hd_byte, hd_eop, h_ack,
		output dd_valid, dd_byte, dd_eop, d_ack, d_nak
	);
	modport host (
		output tok_valid, tok_in, tok_ep, hd_valid, hd_byte, hd_eop, h_ack,
		input dd_valid, dd_byte, dd_eop, d_ack, d_nak
	);
endinterface // uecor_link_if

/* core/uecor_window.sv */
`timescale 1ns/1ps

module uecor_window (
	input wire uecor_pkg::uecor_addr_t base,
	input wire logic bank,
	input wire logic [1:0] offset,
	output uecor_pkg::uecor_addr_t start
);
	import uecor_pkg::*;

	always_comb begin
		start = base;
		if (bank) begin
			start = 16'(start + `UECOR_BANK_STEP);
		end
		start = 16'(start + 16'(`UECOR_OFS_STEP * {14'h0000, offset}));
	end
endmodule // uecor_window

/* core/uecor_device.sv */
// Behaviour
// - Seven-bit received count for endpoints one to four
// - Endpoint 1 count loads only on ACKed OUT
// - Endpoint 2 count updates on ACKed OUT and on software write
// - Endpoint 3 count refreshes on ACKed OUT
// - Endpoint 4 count captures on ACKed OUT
// - Endpoint 2 IN: software writes bytes to send
// - Endpoint 2 OUT: software writes maximum payload
// - Endpoint 3 IN: software writes bytes to send
// - Endpoint 3 OUT: software writes maximum payload
// - Endpoint 4 IN: length written before token
// - Endpoint 4 OUT: software writes maximum payload
// - Lengths only 0 to 64; bit 7 unused (length registers still accept 65 to 127, no clamp)
// - Test control is read/write, resets zero
// - Read-only test readback register, resets zero
// - Offset register: two bits per endpoint
// - Endpoint 2 offset bits 3:2 plus bank
// - Endpoint 2 window 0300 plus bank, offset steps
// - Endpoint 3 window 0380 plus bank, offset steps
// - Endpoint 4 window 0380 (same base as endpoint 3) plus bank, offset steps
// - Direction one: IN only; zero: OUT only
`timescale 1ns/1ps

module uecor_device (
	input wire logic core_clk,
	input wire logic rst_n,
	uecor_link_if.dev link,
	input wire uecor_pkg::uecor_addr_t sw_addr,
	input wire uecor_pkg::uecor_byte_t sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output uecor_pkg::uecor_byte_t sw_rdata,
	input wire logic [3:0] ep_dir,
	input wire logic [3:0] ep_bank,
	output uecor_pkg::uecor_addr_t ram_addr,
	output uecor_pkg::uecor_byte_t ram_wdata,
	output logic ram_we,
	input wire uecor_pkg::uecor_byte_t ram_rdata
);
	import uecor_pkg::*;

	uecor_dev_t r;
	uecor_dev_t next_r;
	uecor_addr_t win [4];
	uecor_addr_t base [4];
	logic tok_ok;
	logic [1:0] tok_idx;

	assign base[0] = `UECOR_EP1_BUF_BASE;
	assign base[1] = `UECOR_EP2_BUF_BASE;
	assign base[2] = `UECOR_EP34_BUF_BASE;
	assign base[3] = `UECOR_EP34_BUF_BASE;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_win
			uecor_window u_win (
				.base(base[gi]),
				.bank(ep_bank[gi]),
				.offset(r.offsets[2*gi+1:2*gi]),
				.start(win[gi])
			);
		end
	endgenerate

	// Endpoint 0 belongs to the control path, not here
	assign tok_idx = 2'(link.tok_ep - 3'h1);
	assign tok_ok = (link.tok_ep != 3'h0) && (link.tok_ep <= 3'h4)
		&& (ep_dir[tok_idx] == link.tok_in);

	always_comb begin
		next_r = r;
		next_r.ram_we = 1'b0;
		next_r.dd_valid = 1'b0;
		next_r.dd_eop = 1'b0;
		next_r.d_ack = 1'b0;
		next_r.d_nak = 1'b0;

		// Bit 7 of length registers is dropped on write
		if (sw_wr) begin
			if (sw_addr == `UECOR_EP1_LENGTH) begin
				next_r.length[0] = sw_wdata[6:0];
			end else if (sw_addr == `UECOR_EP2_LENGTH) begin
				next_r.length[1] = sw_wdata[6:0];
			end else if (sw_addr == `UECOR_EP2_RX) begin
				next_r.rx[1] = sw_wdata[6:0];
			end else if (sw_addr == `UECOR_EP3_LENGTH) begin
				next_r.length[2] = sw_wdata[6:0];
			end else if (sw_addr == `UECOR_EP3_RX) begin
				next_r.rx[2] = sw_wdata[6:0];
			end else if (sw_addr == `UECOR_EP4_LENGTH) begin
				next_r.length[3] = sw_wdata[6:0];
			end else if (sw_addr == `UECOR_EP4_RX) begin
				next_r.rx[3] = sw_wdata[6:0];
			end else if (sw_addr == `UECOR_TEST_CONTROL) begin
				next_r.test_control = sw_wdata;
			end else if (sw_addr == `UECOR_BUF_OFFSETS) begin
				next_r.offsets = sw_wdata;
			end
		end

		next_r.rdata = `UECOR_UNMAPPED_READ;
		if (sw_rd) begin
			if (sw_addr == `UECOR_EP1_LENGTH) begin
				next_r.rdata = {1'b0, r.length[0]};
			end else if (sw_addr == `UECOR_EP1_RX) begin
				next_r.rdata = {1'b0, r.rx[0]};
			end else if (sw_addr == `UECOR_EP2_LENGTH) begin
				next_r.rdata = {1'b0, r.length[1]};
			end else if (sw_addr == `UECOR_EP2_RX) begin
				next_r.rdata = {1'b0, r.rx[1]};
			end else if (sw_addr == `UECOR_EP3_LENGTH) begin
				next_r.rdata = {1'b0, r.length[2]};
			end else if (sw_addr == `UECOR_EP3_RX) begin
				next_r.rdata = {1'b0, r.rx[2]};
			end else if (sw_addr == `UECOR_EP4_LENGTH) begin
				next_r.rdata = {1'b0, r.length[3]};
			end else if (sw_addr == `UECOR_EP4_RX) begin
				next_r.rdata = {1'b0, r.rx[3]};
			end else if (sw_addr == `UECOR_TEST_CONTROL) begin
				next_r.rdata = r.test_control;
			end else if (sw_addr == `UECOR_TEST_READBACK) begin
				next_r.rdata = `UECOR_TEST_READBACK_RESET;
			end else if (sw_addr == `UECOR_BUF_OFFSETS) begin
				next_r.rdata = r.offsets;
			end
		end

		case (r.st)
			DEV_IDLE: begin
				// Wrong-direction tokens are dropped without answer
				if (link.tok_valid && tok_ok) begin
					next_r.ep = tok_idx;
					next_r.idx = `UECOR_LEN_RESET;
					// Length latched now so a late write cannot cut a packet
					next_r.lim = r.length[tok_idx];
					next_r.ram_addr = win[tok_idx];
					next_r.st = link.tok_in ? DEV_SEND : DEV_RECV;
				end
			end
			DEV_SEND: begin
				if (r.idx != r.lim) begin
					next_r.dd_valid = 1'b1;
					next_r.dd_byte = ram_rdata;
					next_r.ram_addr = 16'(r.ram_addr + 16'h0001);
					next_r.idx = 7'(r.idx + 7'h01);
				end else begin
					next_r.dd_eop = 1'b1;
					next_r.st = DEV_WAIT;
				end
			end
			DEV_WAIT: begin
				// A fresh token also releases us if the handshake was lost
				if (link.h_ack || link.tok_valid) begin
					next_r.st = DEV_IDLE;
				end
			end
			DEV_RECV: begin
				if (link.hd_valid) begin
					// Bytes past the maximum never touch the neighbour's window
					if (r.idx < r.lim) begin
						next_r.ram_we = 1'b1;
						next_r.ram_wdata = link.hd_byte;
						next_r.ram_addr = 16'(win[r.ep] + {9'h000, r.idx});
					end
					if (r.idx != `UECOR_CNT_SAT) begin
						next_r.idx = 7'(r.idx + 7'h01);
					end
				end else if (link.hd_eop) begin
					if (r.idx <= r.lim) begin
						next_r.d_ack = 1'b1;
						// Hardware load wins over a same-cycle software write
						next_r.rx[r.ep] = r.idx;
					end else begin
						next_r.d_nak = 1'b1;
					end
					next_r.st = DEV_IDLE;
				end
			end
			default: begin
				next_r.st = DEV_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r <= '0;
			r.test_control <= `UECOR_TEST_CONTROL_RESET;
			r.offsets <= `UECOR_BUF_OFFSETS_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign sw_rdata = r.rdata;
	assign ram_addr = r.ram_addr;
	assign ram_wdata = r.ram_wdata;
	assign ram_we = r.ram_we;
	assign link.dd_valid = r.dd_valid;
	assign link.dd_byte = r.dd_byte;
	assign link.dd_eop = r.dd_eop;
	assign link.d_ack = r.d_ack;
	assign link.d_nak = r.d_nak;
endmodule // uecor_device

/* core/uecor_host.sv */
`timescale 1ns/1ps

module uecor_host (
	input wire logic core_clk,
	input wire logic rst_n,
	uecor_link_if.host link,
	input wire logic cmd_valid,
	input wire logic cmd_in,
	input wire uecor_pkg::uecor_ep_t cmd_ep,
	input wire uecor_pkg::uecor_len_t cmd_len,
	input wire uecor_pkg::uecor_byte_t cmd_seed,
	output logic cmd_ready,
	output logic done,
	output logic done_ok,
	output uecor_pkg::uecor_len_t done_count,
	output uecor_pkg::uecor_byte_t done_sum
);
	import uecor_pkg::*;

	uecor_host_t r;
	uecor_host_t next_r;

	always_comb begin
		next_r = r;
		next_r.tok_valid = 1'b0;
		next_r.hd_valid = 1'b0;
		next_r.hd_eop = 1'b0;
		next_r.h_ack = 1'b0;
		next_r.done = 1'b0;
		next_r.timer = 8'(r.timer + 8'h01);

		case (r.st)
			HOST_IDLE: begin
				next_r.timer = 8'h00;
				if (cmd_valid) begin
					next_r.tok_valid = 1'b1;
					next_r.tok_in = cmd_in;
					next_r.tok_ep = cmd_ep;
					next_r.is_in = cmd_in;
					// Payload capped at the legal maximum
					next_r.len = (cmd_len > `UECOR_MAX_PAYLOAD) ?
						`UECOR_MAX_PAYLOAD : cmd_len;
					next_r.seed = cmd_seed;
					next_r.cnt = `UECOR_LEN_RESET;
					next_r.sum = 8'h00;
					next_r.st = cmd_in ? HOST_RECV : HOST_SEND;
				end
			end
			HOST_SEND: begin
				if (r.cnt != r.len) begin
					next_r.hd_valid = 1'b1;
					next_r.hd_byte = 8'(r.seed + {1'b0, r.cnt});
					next_r.cnt = 7'(r.cnt + 7'h01);
				end else begin
					next_r.hd_eop = 1'b1;
					next_r.timer = 8'h00;
					next_r.st = HOST_WAIT_HS;
				end
			end
			HOST_WAIT_HS: begin
				// Silence means the endpoint refused the token
				if (link.d_ack || link.d_nak || r.timer == `UECOR_HOST_TIMEOUT) begin
					next_r.done = 1'b1;
					next_r.done_ok = link.d_ack;
					next_r.done_count = r.cnt;
					next_r.done_sum = 8'h00;
					next_r.st = HOST_IDLE;
				end
			end
			HOST_RECV: begin
				if (link.dd_valid) begin
					next_r.timer = 8'h00;
					next_r.sum = 8'(r.sum + link.dd_byte);
					if (r.cnt != `UECOR_CNT_SAT) begin
						next_r.cnt = 7'(r.cnt + 7'h01);
					end
				end else if (link.dd_eop || r.timer == `UECOR_HOST_TIMEOUT) begin
					next_r.h_ack = link.dd_eop;
					next_r.done = 1'b1;
					next_r.done_ok = link.dd_eop;
					next_r.done_count = r.cnt;
					next_r.done_sum = r.sum;
					next_r.st = HOST_IDLE;
				end
			end
			default: begin
				next_r.st = HOST_IDLE;
			end
		endcase
		next_r.ready = (next_r.st == HOST_IDLE) && !next_r.tok_valid;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign link.tok_valid = r.tok_valid;
	assign link.tok_in = r.tok_in;
	assign link.tok_ep = r.tok_ep;
	assign link.hd_valid = r.hd_valid;
	assign link.hd_byte = r.hd_byte;
	assign link.hd_eop = r.hd_eop;
	assign link.h_ack = r.h_ack;
	assign cmd_ready = r.ready;
	assign done = r.done;
	assign done_ok = r.done_ok;
	assign done_count = r.done_count;
	assign done_sum = r.done_sum;
endmodule // uecor_host

/* dv/uecor_link_monitor.sv */
`timescale 1ns/1ps

module uecor_link_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tok_valid,
	input wire logic tok_in,
	input wire uecor_pkg::uecor_ep_t tok_ep,
	input wire logic hd_eop,
	input wire logic h_ack,
	input wire logic dd_valid,
	input wire logic dd_eop,
	input wire logic d_ack,
	input wire logic d_nak
);
	import uecor_pkg::*;
	default clocking mon_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_in_tok;
		tok_valid && tok_in;
	endsequence
	sequence s_out_end;
		hd_eop ##1 (d_ack || d_nak);
	endsequence

	chk_ack_or_nak: assert property (!(d_ack && d_nak))
		else $error("ack and nak together");
	chk_answer_after_eop: assert property ((d_ack || d_nak) |-> $past(hd_eop))
		else $error("handshake without end of data");
	chk_single_answer: assert property (s_out_end |=> !(d_ack || d_nak))
		else $error("handshake repeated");
	chk_no_answer_in: assert property (s_in_tok |=> (!d_ack && !d_nak)[*4])
		else $error("handshake after IN token");
	chk_first_byte: assert property (dd_valid && !$past(dd_valid)
		|-> $past(tok_valid, 2) && $past(tok_in, 2))
		else $error("first IN byte off time");
	chk_eop_after_data: assert property (dd_eop |-> !dd_valid
		&& ($past(dd_valid) || ($past(tok_valid, 2) && $past(tok_in, 2))))
		else $error("IN end without data or token");
	chk_idle_ep: assert property (tok_valid && (tok_ep == 3'h0 || tok_ep > 3'h4)
		|=> (!dd_valid && !dd_eop && !d_ack && !d_nak)[*3])
		else $error("answer to unserved endpoint");
	chk_hack_after_eop: assert property (h_ack |-> $past(dd_eop))
		else $error("host ack without packet end");
endmodule // uecor_link_monitor

/* dv/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
	import uecor_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	uecor_addr_t sw_addr = 16'h0;
	uecor_byte_t sw_wdata = 8'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	uecor_byte_t sw_rdata;
	logic [3:0] ep_dir = 4'h0;
	logic [3:0] ep_bank = 4'h0;
	uecor_addr_t ram_addr;
	uecor_byte_t ram_wdata;
	logic ram_we;
	uecor_byte_t ram_rdata;
	logic cmd_valid = 1'b0;
	logic cmd_in = 1'b0;
	uecor_ep_t cmd_ep = 3'h0;
	uecor_len_t cmd_len = 7'h0;
	uecor_byte_t cmd_seed = 8'h0;
	logic cmd_ready, done, done_ok;
	uecor_len_t done_count;
	uecor_byte_t done_sum;
	int bad_count = 0;
	int n_compared = 0;
	logic [31:0] rs = 32'hC0646017;
	int len_m [1:4];
	int rx_m [1:4];
	logic [7:0] ofs_m;
	uecor_byte_t cur_seed = 8'h00;
	logic [23:0] wq [$];

	uecor_link_if link();
	uecor_device uecor_device_i(.core_clk, .rst_n, .link(link.dev), .sw_addr, .sw_wdata,
		.sw_wr, .sw_rd, .sw_rdata, .ep_dir, .ep_bank, .ram_addr, .ram_wdata, .ram_we,
		.ram_rdata);
	uecor_host uecor_host_i(.core_clk, .rst_n, .link(link.host), .cmd_valid, .cmd_in,
		.cmd_ep, .cmd_len, .cmd_seed, .cmd_ready, .done, .done_ok, .done_count, .done_sum);
	uecor_link_monitor uecor_link_monitor_i(.core_clk, .rst_n, .tok_valid(link.tok_valid),
		.tok_in(link.tok_in), .tok_ep(link.tok_ep), .hd_eop(link.hd_eop), .h_ack(link.h_ack),
		.dd_valid(link.dd_valid), .dd_eop(link.dd_eop), .d_ack(link.d_ack), .d_nak(link.d_nak));

	always #10 core_clk = ~core_clk;
	// Content derived from address, so a wrong window start changes the sum
	assign ram_rdata = ram_addr[7:0] ^ ram_addr[15:8];

	// Every buffer write is matched against the queue of expected address and byte
	always @(posedge core_clk) begin
		if (ram_we === 1'b1) begin
			if (wq.size() == 0)
				chk("ram write", 32'hFFFFFFFF, {ram_addr, ram_wdata});
			else
				chk("ram write", wq.pop_front(), {ram_addr, ram_wdata});
		end
	end

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	function automatic uecor_addr_t win(int ep);
		uecor_addr_t b;
		b = ep == 1 ? 16'h0280 : ep == 2 ? 16'h0300 : 16'h0380;
		return b + 16'h0040 * ep_bank[ep-1] + 16'h0010 * ofs_m[2*ep-2 +: 2];
	endfunction

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("unexpected %s expected %0h seen %0h", nm, e, g);
			bad_count++;
		end
	endtask

	task automatic wr(uecor_addr_t a, uecor_byte_t d);
		@(posedge core_clk);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask

	task automatic rd(uecor_addr_t a, uecor_byte_t e);
		@(posedge core_clk);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		#1;
		chk($sformatf("register %h", a), e, sw_rdata);
	endtask

	task automatic xfer(logic in, int ep, int n);
		logic ok;
		int k;
		int s;
		uecor_addr_t a;
		// Decide after the edge so level inputs set by NBA have landed
		@(posedge core_clk);
		ok = 1'b0;
		if (ep >= 1 && ep <= 4)
			ok = in ? ep_dir[ep-1] : !ep_dir[ep-1] && n <= len_m[ep];
		if (ok && !in)
			rx_m[ep] = n;
		s = 0;
		for (k = 0; ok && in && k < len_m[ep]; k++) begin
			a = win(ep) + 16'(k);
			s += a[7:0] ^ a[15:8];
		end
		cur_seed = 8'(rnd());
		// OUT bytes within the maximum land in the window in order, even on refusal
		if (!in && ep >= 1 && ep <= 4 && !ep_dir[ep-1]) begin
			for (k = 0; k < n && k < len_m[ep]; k++) begin
				a = win(ep) + 16'(k);
				wq.push_back({a, 8'(cur_seed + 8'(k))});
			end
		end
		cmd_valid <= 1'b1;
		cmd_in <= in;
		cmd_ep <= 3'(ep);
		cmd_len <= 7'(n);
		cmd_seed <= cur_seed;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (done !== 1'b1 && k < 400);
		chk("done", 1'b1, done);
		chk("done_ok", ok, done_ok);
		if (ok)
			chk("done_count", in ? len_m[ep] : n, done_count);
		if (ok && in)
			chk("done_sum", s[7:0], done_sum);
		chk("ram writes left", 32'h0, wq.size());
		wq.delete();
	endtask

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		int r, i, e;
		for (r = 0; r < 2; r++) begin
			rst_n <= 1'b0;
			repeat (12) @(posedge core_clk);
			rst_n <= 1'b1;
			rx_m = '{0, 0, 0, 0};
			for (i = 0; i < 11; i++)
				rd(16'(i < 8 ? 16'hFE98 + i : 16'hFEA4 + i), 8'h00);
			wr(16'hFE99, 8'h55);
			wr(16'hFEAD, 8'hA5);
			wr(16'hFEB0, 8'h3C);
			rd(16'hFE99, 8'h00);
			rd(16'hFEAD, 8'h00);
			rd(16'hFEB0, 8'h00);
			ofs_m = 8'(rnd());
			wr(16'hFEAE, ofs_m);
			rd(16'hFEAE, ofs_m);
			ep_dir <= 4'h0;
			ep_bank <= 4'(rnd());
			for (e = 1; e < 5; e++) begin
				len_m[e] = r ? 64 : rnd() % 65;
				// Bit 7 set on purpose: it must read back as zero
				wr(16'(16'hFE96 + 2 * e), 8'h80 | 8'(len_m[e]));
				rd(16'(16'hFE96 + 2 * e), 8'(len_m[e]));
				xfer(1'b0, e, len_m[e]);
				xfer(1'b0, e, (len_m[e] + 1) % 65);
				rd(16'(16'hFE97 + 2 * e), 8'(rx_m[e]));
			end
			ep_dir <= 4'hF;
			for (e = 1; e < 5; e++) begin
				// IN lengths stay as written above, ahead of the token
				xfer(1'b1, e, 0);
				xfer(1'b0, e, 1);
				rd(16'(16'hFE97 + 2 * e), 8'(rx_m[e]));
			end
			xfer(1'b1, 0, 0);
			xfer(1'b0, 0, 0);
			xfer(1'b0, 7, 1);
		end
		stop_test();
	end

	initial begin
		#500000;
		bad_count++;
		stop_test();
	end
endmodule // tb_top
